// ---- include/lcdhi_pkg.sv ----
package lcdhi_pkg;

    // Host interface modes, coded as the two strap levels {high, low}
    typedef enum logic [1:0] {
        LCDHI_MODE_I2C  = 2'h0,
        LCDHI_MODE_CSI  = 2'h1,
        LCDHI_MODE_BUS8 = 2'h2,
        LCDHI_MODE_BUS4 = 2'h3
    } lcdhi_mode_t;

    // Drive level of one multiplexed LCD output pin
    typedef enum logic [1:0] {
        LCDHI_LVL_VCC    = 2'h0,
        LCDHI_LVL_SEL    = 2'h1,
        LCDHI_LVL_NONSEL = 2'h3,
        LCDHI_LVL_AGND   = 2'h2
    } lcdhi_lvl_t;

    // Panel geometry
    localparam int LCDHI_NUM_COM = 32;
    localparam int LCDHI_COM_PER_ROW = 8;
    localparam int LCDHI_NUM_SEG = 60;
    localparam int LCDHI_NUM_ASEG = 10;

    // Host bus widths
    localparam int LCDHI_DB_W = 8;
    localparam int LCDHI_NIB_W = 4;
    localparam int LCDHI_ID_W = 6;
    localparam int LCDHI_AC_W = 7;

    // Serial framing: bit counts and start byte layout {id[5:0], rs, rw}
    localparam logic [3:0] LCDHI_BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LCDHI_ACK_SLOT = 4'h9;
    localparam logic [2:0] LCDHI_LAST_BIT = 3'h7;
    localparam int LCDHI_START_ID_LSB = 2;
    localparam int LCDHI_START_RS_BIT = 1;
    localparam int LCDHI_START_RW_BIT = 0;

    // Static annunciator levels
    localparam logic LCDHI_ANN_VCC = 1'b1;
    localparam logic LCDHI_ANN_AGND = 1'b0;

    // Pins that enter from the host side, bundled for one synchroniser
    typedef struct packed {
        logic [1:0] iface_strap;
        logic reg_sel_or_chip_sel;
        logic rw_or_sda;
        logic strobe;
        logic ext_alt;
        logic [LCDHI_DB_W-1:0] data_line;
    } lcdhi_pins_t;

    // One completed host write
    typedef struct packed {
        logic is_data;
        logic [LCDHI_DB_W-1:0] data;
    } lcdhi_wr_t;

    // Everything that goes to the glass
    typedef struct packed {
        lcdhi_lvl_t [LCDHI_NUM_COM-1:0] char_common_outputs;
        lcdhi_lvl_t [LCDHI_NUM_SEG-1:0] segment_outputs;
        logic annunciator_common;
        logic [LCDHI_NUM_ASEG-1:0] annunciator_segments;
    } lcdhi_lcd_t;

    // Strap decode, shared by capture logic and its checks
    function automatic lcdhi_mode_t lcdhi_mode_dec(input logic [1:0] strap);
        lcdhi_mode_t m;
        m = LCDHI_MODE_I2C;
        unique case (strap)
            2'h0: m = LCDHI_MODE_I2C;
            2'h1: m = LCDHI_MODE_CSI;
            2'h2: m = LCDHI_MODE_BUS8;
            2'h3: m = LCDHI_MODE_BUS4;
        endcase
        return m;
    endfunction

endpackage

// ---- rtl/lcdhi_sync2.sv ----
`timescale 1ns/1ps

// Two-flop synchroniser for a bundle of independent levels
module lcdhi_sync2 #(
    parameter int W = 1
) (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    // First stage: only the second stage may look at it
    logic [W-1:0] meta_r;
    // Second stage: safe for the core domain
    logic [W-1:0] sync_r;

    // Both stages freeze with the clock enable
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            meta_r <= '0;
            sync_r <= '0;
        end else if (ce_in) begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;

endmodule

// ---- rtl/lcdhi_ser_rx.sv ----
`timescale 1ns/1ps

// Clocked serial shifter, runs on the host's serial clock
module lcdhi_ser_rx (
    input wire logic lnk_clk_in,
    input wire logic frame_clr_in,
    input wire logic core_rst_in,
    input wire logic sdi_in,
    output logic [lcdhi_pkg::LCDHI_DB_W-1:0] byte_out,
    output logic first_out,
    output logic byte_tgl_out
);

    // Bit position within the byte being shifted
    logic [2:0] bit_cnt_r;
    // Partial byte
    logic [lcdhi_pkg::LCDHI_DB_W-2:0] shift_r;
    // Next completed byte is the start byte of the frame
    logic first_pend_r;
    // Completed byte, held still until the next one ends
    logic [lcdhi_pkg::LCDHI_DB_W-1:0] byte_r;
    // Start-byte marker travelling with byte_r
    logic first_r;
    // Flips once per completed byte; the core sees the event by its change
    logic tgl_r;

    wire byte_done = (bit_cnt_r == lcdhi_pkg::LCDHI_LAST_BIT);

    // Framing state: cleared while the chip is not selected, so a stopped
    // clock between frames leaves nothing half-counted
    always_ff @(posedge lnk_clk_in or posedge frame_clr_in) begin
        if (frame_clr_in) begin
            bit_cnt_r <= 3'h0;
            shift_r <= '0;
            first_pend_r <= 1'b1;
        end else begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
            shift_r <= {shift_r[lcdhi_pkg::LCDHI_DB_W-3:0], sdi_in};
            if (byte_done) begin
                first_pend_r <= 1'b0;
            end
        end
    end

    // Hand-over registers: only core reset clears them, so deselect never
    // fakes a toggle event
    always_ff @(posedge lnk_clk_in or posedge core_rst_in) begin
        if (core_rst_in) begin
            byte_r <= '0;
            first_r <= 1'b0;
            tgl_r <= 1'b0;
        end else if (byte_done && !frame_clr_in) begin
            byte_r <= {shift_r, sdi_in};
            first_r <= first_pend_r;
            tgl_r <= ~tgl_r;
        end
    end

    assign byte_out = byte_r;
    assign first_out = first_r;
    assign byte_tgl_out = tgl_r;

endmodule

// ---- rtl/lcdhi_host_port.sv ----
`timescale 1ns/1ps

module lcdhi_host_port (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic strobe_clk_in,
    input wire logic [1:0] iface_strap_in,
    input wire logic reg_sel_or_chip_sel_in,
    input wire logic rw_or_sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic [lcdhi_pkg::LCDHI_DB_W-1:0] data_line_in,
    output logic [lcdhi_pkg::LCDHI_DB_W-1:0] data_line_out,
    output logic [lcdhi_pkg::LCDHI_DB_W-1:0] data_line_oe_out,
    output lcdhi_pkg::lcdhi_mode_t mode_out,
    output logic wr_stb_out,
    output lcdhi_pkg::lcdhi_wr_t wr_out,
    output logic rd_stb_out,
    input wire logic busy_in,
    input wire logic [lcdhi_pkg::LCDHI_AC_W-1:0] addr_cnt_in,
    input wire logic [lcdhi_pkg::LCDHI_DB_W-1:0] rd_data_in,
    input wire logic sleep_bit_in,
    input wire logic standby_in,
    input wire logic [1:0] rows_used_in,
    input wire logic [lcdhi_pkg::LCDHI_NUM_COM-1:0] com_sel_in,
    input wire logic [lcdhi_pkg::LCDHI_NUM_SEG-1:0] seg_on_in,
    input wire logic annunciator_on_bit_in,
    input wire logic [lcdhi_pkg::LCDHI_NUM_ASEG-1:0] ann_pat_in,
    input wire logic frame_alt_in,
    input wire logic ext_alt_in,
    output lcdhi_pkg::lcdhi_lcd_t lcd_out
);

    // Two-wire receiver states, Gray along idle-address-data
    typedef enum logic [1:0] {
        LCDHI_I2C_IDLE = 2'h0,
        LCDHI_I2C_ADDR = 2'h1,
        LCDHI_I2C_DATA = 2'h3,
        LCDHI_I2C_SKIP = 2'h2
    } lcdhi_i2c_st_t;

    // ---------------- Pin synchronisation ----------------
    lcdhi_pkg::lcdhi_pins_t pins_raw;
    lcdhi_pkg::lcdhi_pins_t pins_s;
    logic ser_tgl;
    logic ser_tgl_s;
    logic [lcdhi_pkg::LCDHI_DB_W-1:0] ser_byte;
    logic ser_first;

    assign pins_raw = '{iface_strap: iface_strap_in,
                        reg_sel_or_chip_sel: reg_sel_or_chip_sel_in,
                        rw_or_sda: rw_or_sda_in,
                        strobe: strobe_clk_in,
                        ext_alt: ext_alt_in,
                        data_line: data_line_in};

    // One synchroniser for every pin plus the serial byte toggle
    lcdhi_sync2 #(.W($bits(lcdhi_pkg::lcdhi_pins_t) + 1)) u_sync (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce_in),
        .async_in({ser_tgl, pins_raw}),
        .sync_out({ser_tgl_s, pins_s})
    );

    // ---------------- Mode capture ----------------
    lcdhi_pkg::lcdhi_mode_t mode_r;
    logic mode_ok_r;     // Mode taken; port logic is dead until then
    logic [1:0] prime_r; // Ones walk in after reset; full once straps are through

    // Straps caught once the synchroniser holds them rather than its reset
    // value; later changes are not followed
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            mode_r <= lcdhi_pkg::LCDHI_MODE_I2C;
            mode_ok_r <= 1'b0;
            prime_r <= 2'h0;
        end else if (ce_in) begin
            prime_r <= {prime_r[0], 1'b1};
            if (prime_r[1] && !mode_ok_r) begin
                mode_r <= lcdhi_pkg::lcdhi_mode_dec(pins_s.iface_strap);
                mode_ok_r <= 1'b1;
            end
        end
    end

    wire is_i2c = mode_ok_r && (mode_r == lcdhi_pkg::LCDHI_MODE_I2C);
    wire is_csi = mode_ok_r && (mode_r == lcdhi_pkg::LCDHI_MODE_CSI);
    wire is_bus8 = mode_ok_r && (mode_r == lcdhi_pkg::LCDHI_MODE_BUS8);
    wire is_bus4 = mode_ok_r && (mode_r == lcdhi_pkg::LCDHI_MODE_BUS4);
    wire is_par = is_bus8 || is_bus4;

    // Previous synced samples for edge detection
    logic strobe_q_r;
    logic sda_q_r;
    wire strobe_rise = pins_s.strobe && !strobe_q_r;
    wire strobe_fall = !pins_s.strobe && strobe_q_r;
    wire [lcdhi_pkg::LCDHI_ID_W-1:0] strap_id = pins_s.data_line[lcdhi_pkg::LCDHI_ID_W-1:0];

    // ---------------- Clocked serial (link domain) ----------------
    // Deselect or a different mode holds the shifter cleared
    wire csi_clr = reg_sel_or_chip_sel_in || !is_csi;

    lcdhi_ser_rx u_ser (
        .lnk_clk_in(strobe_clk_in),
        .frame_clr_in(csi_clr),
        .core_rst_in(!rst_n_in),
        .sdi_in(rw_or_sda_in),
        .byte_out(ser_byte),
        .first_out(ser_first),
        .byte_tgl_out(ser_tgl)
    );

    logic ser_seen_r;    // Last toggle level taken
    logic csi_sel_ok_r;  // Start byte matched in this frame
    logic csi_rs_r;      // Target chosen by the start byte
    wire ser_new = is_csi && (ser_tgl_s != ser_seen_r);
    wire [lcdhi_pkg::LCDHI_ID_W-1:0] ser_id = ser_byte[lcdhi_pkg::LCDHI_DB_W-1:
        lcdhi_pkg::LCDHI_START_ID_LSB];
    wire csi_start_ok = (ser_id == strap_id) && !ser_byte[lcdhi_pkg::LCDHI_START_RW_BIT];
    wire csi_emit = ser_new && !ser_first && csi_sel_ok_r;

    // Start byte vets the frame; deselect ends it
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            ser_seen_r <= 1'b0;
            csi_sel_ok_r <= 1'b0;
            csi_rs_r <= 1'b0;
        end else if (ce_in) begin
            ser_seen_r <= ser_tgl_s;
            if (pins_s.reg_sel_or_chip_sel) begin
                csi_sel_ok_r <= 1'b0;
            end else if (ser_new && ser_first) begin
                csi_sel_ok_r <= csi_start_ok;
                csi_rs_r <= ser_byte[lcdhi_pkg::LCDHI_START_RS_BIT];
            end
        end
    end

    // ---------------- Two-wire receiver (oversampled) ----------------
    lcdhi_i2c_st_t i2c_st_r;
    logic [3:0] i2c_cnt_r;   // Bits seen, then the ack slot
    logic [lcdhi_pkg::LCDHI_DB_W-1:0] i2c_sh_r;
    logic i2c_ack_r;         // Holding the data pin low
    logic i2c_rs_r;

    wire i2c_start = is_i2c && pins_s.strobe && strobe_q_r && sda_q_r && !pins_s.rw_or_sda;
    wire i2c_stop = is_i2c && pins_s.strobe && strobe_q_r && !sda_q_r && pins_s.rw_or_sda;
    wire i2c_busy = (i2c_st_r == LCDHI_I2C_ADDR) || (i2c_st_r == LCDHI_I2C_DATA);
    wire i2c_byte_end = i2c_busy && strobe_fall && (i2c_cnt_r == lcdhi_pkg::LCDHI_BITS_PER_BYTE);
    wire i2c_slot_end = strobe_fall && (i2c_cnt_r == lcdhi_pkg::LCDHI_ACK_SLOT);
    wire [lcdhi_pkg::LCDHI_ID_W-1:0] i2c_id = i2c_sh_r[lcdhi_pkg::LCDHI_DB_W-1:
        lcdhi_pkg::LCDHI_START_ID_LSB];
    wire i2c_addr_ok = (i2c_id == strap_id) && !i2c_sh_r[lcdhi_pkg::LCDHI_START_RW_BIT];
    wire i2c_emit = i2c_byte_end && (i2c_st_r == LCDHI_I2C_DATA);

    // Start and stop win over bit traffic; a refused address is left alone
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            i2c_st_r <= LCDHI_I2C_IDLE;
            i2c_cnt_r <= 4'h0;
            i2c_sh_r <= '0;
            i2c_ack_r <= 1'b0;
            i2c_rs_r <= 1'b0;
        end else if (ce_in) begin
            if (i2c_start) begin
                i2c_st_r <= LCDHI_I2C_ADDR;
                i2c_cnt_r <= 4'h0;
                i2c_ack_r <= 1'b0;
            end else if (i2c_stop) begin
                i2c_st_r <= LCDHI_I2C_IDLE;
                i2c_ack_r <= 1'b0;
            end else if (i2c_busy) begin
                if (strobe_rise && i2c_cnt_r < lcdhi_pkg::LCDHI_ACK_SLOT) begin
                    i2c_cnt_r <= i2c_cnt_r + 4'h1;
                    if (i2c_cnt_r < lcdhi_pkg::LCDHI_BITS_PER_BYTE) begin
                        i2c_sh_r <= {i2c_sh_r[lcdhi_pkg::LCDHI_DB_W-2:0], pins_s.rw_or_sda};
                    end
                end else if (i2c_byte_end) begin
                    if (i2c_st_r == LCDHI_I2C_DATA) begin
                        i2c_ack_r <= 1'b1;
                    end else if (i2c_addr_ok) begin
                        i2c_ack_r <= 1'b1;
                        i2c_rs_r <= i2c_sh_r[lcdhi_pkg::LCDHI_START_RS_BIT];
                        i2c_st_r <= LCDHI_I2C_DATA;
                    end else begin
                        i2c_st_r <= LCDHI_I2C_SKIP;
                    end
                end else if (i2c_slot_end) begin
                    i2c_ack_r <= 1'b0;
                    i2c_cnt_r <= 4'h0;
                end
            end
        end
    end

    // Only ever pulls low, never returns read data
    assign sda_out = 1'b0;
    assign sda_oe_out = i2c_ack_r && is_i2c;

    // ---------------- Parallel bus ----------------
    logic nib_lo_r;      // Next four-bit transfer is the low half
    logic [lcdhi_pkg::LCDHI_NIB_W-1:0] nib_hi_r;
    logic [lcdhi_pkg::LCDHI_DB_W-1:0] db_out_r;
    logic [lcdhi_pkg::LCDHI_DB_W-1:0] db_oe_r;

    wire par_cycle = is_par && strobe_fall;
    wire par_wr = par_cycle && !pins_s.rw_or_sda;
    wire par_rd = par_cycle && pins_s.rw_or_sda;
    wire [lcdhi_pkg::LCDHI_NIB_W-1:0] db_hi = pins_s.data_line[lcdhi_pkg::LCDHI_DB_W-1:
        lcdhi_pkg::LCDHI_NIB_W];
    wire par_whole = is_bus8 || nib_lo_r;
    wire par_emit = par_wr && par_whole;
    wire [lcdhi_pkg::LCDHI_DB_W-1:0] par_byte = is_bus8 ? pins_s.data_line : {nib_hi_r, db_hi};
    // Status word for select low; the instruction register has no read path
    wire [lcdhi_pkg::LCDHI_DB_W-1:0] rd_word = pins_s.reg_sel_or_chip_sel ? rd_data_in :
        {busy_in, addr_cnt_in};
    wire [lcdhi_pkg::LCDHI_DB_W-1:0] db_out_nxt = is_bus8 ? rd_word :
        {(nib_lo_r ? rd_word[lcdhi_pkg::LCDHI_NIB_W-1:0] :
         rd_word[lcdhi_pkg::LCDHI_DB_W-1:lcdhi_pkg::LCDHI_NIB_W]),
         {lcdhi_pkg::LCDHI_NIB_W{1'b0}}};
    wire drive_rd = is_par && pins_s.rw_or_sda && pins_s.strobe;
    wire [lcdhi_pkg::LCDHI_DB_W-1:0] db_oe_nxt = !drive_rd ? '0 :
        (is_bus8 ? '1 : {{lcdhi_pkg::LCDHI_NIB_W{1'b1}}, {lcdhi_pkg::LCDHI_NIB_W{1'b0}}});

    // Nibble pairing, read drive and edge history
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            nib_lo_r <= 1'b0;
            nib_hi_r <= '0;
            db_out_r <= '0;
            db_oe_r <= '0;
            strobe_q_r <= 1'b0;
            sda_q_r <= 1'b1;
        end else if (ce_in) begin
            strobe_q_r <= pins_s.strobe;
            sda_q_r <= pins_s.rw_or_sda;
            db_out_r <= db_out_nxt;
            db_oe_r <= db_oe_nxt;
            if (is_bus4 && par_cycle) begin
                nib_lo_r <= !nib_lo_r;
                if (!nib_lo_r) begin
                    nib_hi_r <= db_hi;
                end
            end
        end
    end

    assign data_line_out = db_out_r;
    assign data_line_oe_out = db_oe_r;

    // ---------------- Write and read strobes ----------------
    logic wr_stb_r;
    lcdhi_pkg::lcdhi_wr_t wr_r;
    logic rd_stb_r;
    wire wr_fire = i2c_emit || csi_emit || par_emit;
    lcdhi_pkg::lcdhi_wr_t wr_nxt;
    // Sources are exclusive by mode, so a plain priority mux is enough
    assign wr_nxt = i2c_emit ? '{is_data: i2c_rs_r, data: i2c_sh_r} :
                    csi_emit ? '{is_data: csi_rs_r, data: ser_byte} :
                    '{is_data: pins_s.reg_sel_or_chip_sel, data: par_byte};

    // One-cycle pulses, data held until the next write
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            wr_stb_r <= 1'b0;
            wr_r <= '0;
            rd_stb_r <= 1'b0;
        end else if (ce_in) begin
            wr_stb_r <= wr_fire;
            rd_stb_r <= par_rd && par_whole;
            if (wr_fire) begin
                wr_r <= wr_nxt;
            end
        end
    end

    assign wr_stb_out = wr_stb_r;
    assign wr_out = wr_r;
    assign rd_stb_out = rd_stb_r;
    assign mode_out = mode_r;

    // ---------------- LCD output levels ----------------
    lcdhi_pkg::lcdhi_lcd_t lcd_r;
    lcdhi_pkg::lcdhi_lcd_t lcd_nxt;
    wire blank = sleep_bit_in || standby_in;
    // Standby stops the internal alternation, so the external one is used
    wire ann_alt = standby_in ? pins_s.ext_alt : frame_alt_in;
    wire annunciator_common_lvl = ann_alt ? lcdhi_pkg::LCDHI_ANN_VCC : lcdhi_pkg::LCDHI_ANN_AGND;

    for (genvar c = 0; c < lcdhi_pkg::LCDHI_NUM_COM; c++) begin : g_com
        // Row of this common: c / 8
        wire row_used = ((c / lcdhi_pkg::LCDHI_COM_PER_ROW) <= int'(rows_used_in));
        assign lcd_nxt.char_common_outputs[c] = blank ? lcdhi_pkg::LCDHI_LVL_VCC :
            !row_used ? lcdhi_pkg::LCDHI_LVL_NONSEL :
            com_sel_in[c] ? lcdhi_pkg::LCDHI_LVL_SEL : lcdhi_pkg::LCDHI_LVL_NONSEL;
    end
    for (genvar s = 0; s < lcdhi_pkg::LCDHI_NUM_SEG; s++) begin : g_seg
        assign lcd_nxt.segment_outputs[s] = blank ? lcdhi_pkg::LCDHI_LVL_VCC :
            seg_on_in[s] ? lcdhi_pkg::LCDHI_LVL_SEL : lcdhi_pkg::LCDHI_LVL_NONSEL;
    end
    // Lit segment sits opposite the common; dark one follows it
    assign lcd_nxt.annunciator_common = annunciator_on_bit_in ? annunciator_common_lvl :
        lcdhi_pkg::LCDHI_ANN_VCC;
    assign lcd_nxt.annunciator_segments = !annunciator_on_bit_in ?
        {lcdhi_pkg::LCDHI_NUM_ASEG{lcdhi_pkg::LCDHI_ANN_VCC}} :
        (ann_pat_in ^ {lcdhi_pkg::LCDHI_NUM_ASEG{annunciator_common_lvl}});

    // Glass levels registered; reset shows the blanked state
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            lcd_r <= '{char_common_outputs: '{default: lcdhi_pkg::LCDHI_LVL_VCC},
                       segment_outputs: '{default: lcdhi_pkg::LCDHI_LVL_VCC},
                       annunciator_common: lcdhi_pkg::LCDHI_ANN_VCC,
                       annunciator_segments: '1};
        end else if (ce_in) begin
            lcd_r <= lcd_nxt;
        end
    end

    assign lcd_out = lcd_r;

    // ---------------- Checks ----------------
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_hi_nibble;
        ce_in && is_bus4 && par_wr && !nib_lo_r;
    endsequence

    chk_mode_decode: assert property (mode_ok_r |->
        mode_r == lcdhi_pkg::lcdhi_mode_dec(iface_strap_in) || $changed(iface_strap_in))
        else $error("mode does not follow straps");
    chk_serial_no_drive: assert property ((is_i2c || is_csi) |-> data_line_oe_out == '0)
        else $error("data lines driven in serial mode");
    chk_deselect_drop: assert property (ce_in && is_csi && pins_s.reg_sel_or_chip_sel
        |=> !csi_sel_ok_r && !wr_stb_out)
        else $error("deselected device still accepts");
    chk_par_target: assert property (ce_in && par_emit |=> wr_stb_out &&
        wr_out.is_data == $past(pins_s.reg_sel_or_chip_sel))
        else $error("write landed in wrong register");
    chk_ack_pull_low: assert property (sda_oe_out |-> is_i2c && !sda_out
        && i2c_cnt_r >= lcdhi_pkg::LCDHI_BITS_PER_BYTE)
        else $error("acknowledge outside its slot");
    chk_id_refuse: assert property (ce_in && ser_new && ser_first && !csi_start_ok &&
        !pins_s.reg_sel_or_chip_sel |=> !csi_sel_ok_r)
        else $error("foreign id accepted");
    chk_db_read_only: assert property (data_line_oe_out[lcdhi_pkg::LCDHI_DB_W-1] |->
        is_par && $past(pins_s.rw_or_sda) && $past(pins_s.strobe))
        else $error("data lines driven outside read");
    chk_low_nibble_off: assert property (is_bus4 |->
        data_line_oe_out[lcdhi_pkg::LCDHI_NIB_W-1:0] == '0)
        else $error("low data lines driven in four-bit mode");
    chk_nibble_pair: assert property (s_hi_nibble |=> nib_lo_r && !wr_stb_out)
        else $error("high nibble alone made a write");
    chk_sleep_blank: assert property (ce_in && blank |=>
        lcd_out.char_common_outputs == '0 && lcd_out.segment_outputs == '0)
        else $error("outputs not at supply while blanked");
    chk_ann_off: assert property (ce_in && !annunciator_on_bit_in |=>
        lcd_out.annunciator_segments == '1)
        else $error("annunciator segments driven while off");

endmodule

// ---- tb/lcdhi_host_mdl.sv ----
`timescale 1ns/1ps
// Host model: parallel bus cycles and clocked serial frames
module lcdhi_host_mdl (
    input wire logic core_clk_in,
    output logic strobe_out,
    output logic sel_out,
    output logic rw_out,
    output logic [7:0] db_out
);
    initial begin
        strobe_out = 1'b0;
        sel_out = 1'b1;
        rw_out = 1'b0;
        db_out = 8'h00;
    end
    task automatic w(input int n);
        repeat (n) @(posedge core_clk_in);
        #1;
    endtask
    // Five-cycle setup, then strobe high and low, six cycles each
    task automatic par(input logic rs, input logic rd, input logic [7:0] d);
        sel_out = rs;
        rw_out = rd;
        // Released lines show inverse of last value, not a stale copy
        db_out = rd ? ~db_out : d;
        w(5);
        strobe_out = 1'b1;
        w(6);
        strobe_out = 1'b0;
        w(6);
    endtask
    // Two-wire byte, optional start first; data moves only while the clock is
    // low, and the ninth clock finds the line released to its pull-up
    task automatic i2c(input logic [7:0] b, input logic st);
        if (st) begin
            rw_out = 1'b0;
            w(6);
            strobe_out = 1'b0;
        end
        for (int i = 8; i >= 0; i--) begin
            rw_out = (i == 0) ? 1'b1 : b[i-1];
            w(6);
            strobe_out = 1'b1;
            w(6);
            strobe_out = 1'b0;
        end
    endtask
    // Serial byte, MSB first; clock stands still between frames
    task automatic ser(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            rw_out = b[i];
            #8 strobe_out = 1'b1;
            #16 strobe_out = 1'b0;
            #8;
        end
    endtask
endmodule

// ---- tb/lcdhi_host_port_tb.sv ----
`timescale 1ns/1ps
// Self-checking bench for the host port
module lcdhi_host_port_tb;
    logic clk, rst_n, sleep, stby, ann_on, busy, sda, sda_oe, wr_stb, rd_stb, falt, xalt;
    logic ce = 1'b1;
    logic [1:0] strap, rows;
    logic [31:0] csel;
    wire h_stb, h_sel, h_rw;
    wire [7:0] h_db;
    logic [6:0] ac;
    logic [7:0] rdd, dl_out, dl_oe, seen;
    logic [9:0] pat;
    lcdhi_pkg::lcdhi_mode_t mode;
    lcdhi_pkg::lcdhi_wr_t wr;
    lcdhi_pkg::lcdhi_lcd_t lcd;
    int fails = 0, checked = 0, wrs = 0, rds = 0, oebad = 0, ack = 0;
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    initial {rst_n, strap, sleep, stby, ann_on, busy, ac, rdd, rows, pat, csel, falt, xalt} = 0;
    lcdhi_host_mdl h (.core_clk_in(clk), .strobe_out(h_stb), .sel_out(h_sel), .rw_out(h_rw),
        .db_out(h_db));
    lcdhi_host_port dut_u (.core_clk_in(clk), .rst_n_in(rst_n), .ce_in(ce),
        .strobe_clk_in(h_stb), .iface_strap_in(strap),
        .reg_sel_or_chip_sel_in(h_sel), .rw_or_sda_in(h_rw), .sda_out(sda),
        .sda_oe_out(sda_oe), .data_line_in(h_db), .data_line_out(dl_out),
        .data_line_oe_out(dl_oe), .mode_out(mode), .wr_stb_out(wr_stb), .wr_out(wr),
        .rd_stb_out(rd_stb), .busy_in(busy), .addr_cnt_in(ac), .rd_data_in(rdd),
        .sleep_bit_in(sleep), .standby_in(stby), .rows_used_in(rows),
        .com_sel_in(csel), .seg_on_in({60{1'b1}}), .annunciator_on_bit_in(ann_on),
        .ann_pat_in(pat), .frame_alt_in(falt), .ext_alt_in(xalt), .lcd_out(lcd));
    // Count one-cycle strobes, bus drive cycles while rw is low, and acknowledge cycles
    always @(posedge clk) begin
        if (wr_stb === 1'b1) wrs++;
        if (rd_stb === 1'b1) rds++;
        if (dl_oe === 8'hff || dl_oe === 8'hf0) seen = dl_out;
        if (|dl_oe && h_rw === 1'b0) oebad++;
        if (sda_oe === 1'b1 && sda === 1'b0) ack++;
    end
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        checked++;
        if (s !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    // Straps settle well before reset lets go
    task automatic rst(input logic [1:0] s);
        rst_n = 0;
        strap = s;
        h.w(10);
        rst_n = 1;
        h.w(6);
        chk("mode", mode, s);
    endtask
    task automatic end_of_test;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #200000;
        fails++;
        end_of_test;
    end
    initial begin
        #1;
        rst(2'h2);
        csel = '1;
        h.par(0, 0, 8'ha5);
        h.par(1, 0, 8'h3c);
        chk("wrs", wrs, 2);
        chk("wr", wr, 9'h13c);
        busy = 1;
        ac = 7'h2a;
        rdd = 8'h96;
        h.par(0, 1, 8'h00);
        chk("status", seen, 8'haa);
        h.par(1, 1, 8'h00);
        chk("rdata", seen, 8'h96);
        chk("oebad", oebad, 0);
        chk("rds", rds, 2);
        chk("row1", lcd.char_common_outputs[0], lcdhi_pkg::LCDHI_LVL_SEL);
        chk("unused", lcd.char_common_outputs[31], lcdhi_pkg::LCDHI_LVL_NONSEL);
        rows = 2'h1;
        h.w(3);
        chk("row2", lcd.char_common_outputs[15], lcdhi_pkg::LCDHI_LVL_SEL);
        chk("row3", lcd.char_common_outputs[16], lcdhi_pkg::LCDHI_LVL_NONSEL);
        chk("asegoff", lcd.annunciator_segments, 10'h3ff);
        ann_on = 1;
        pat = 10'h155;
        falt = 1;
        h.w(3);
        chk("annunciator_common", lcd.annunciator_common, 1);
        chk("aseg", lcd.annunciator_segments, 10'h2aa);
        ce = 0;
        sleep = 1;
        h.w(3);
        chk("freeze", |lcd.segment_outputs, 1);
        ce = 1;
        for (int i = 0; i < 2; i++) begin
            {stby, sleep} = 2'h1 << i;
            h.w(5);
            chk("com", |lcd.char_common_outputs, 0);
            chk("seg", |lcd.segment_outputs, 0);
            chk("acomsb", lcd.annunciator_common, i == 0);
        end
        $display("parallel 8-bit test done");
        rst(2'h3);
        h.par(1, 0, 8'h75);
        h.par(1, 0, 8'h8a);
        chk("wr4", {wrs, wr}, {16'd3, 9'h178});
        ac = 7'h25;
        h.par(0, 1, 8'h00);
        chk("nib_hi", seen, 8'ha0);
        h.par(0, 1, 8'h00);
        chk("nib_lo", seen, 8'h50);
        chk("rd4", rds, 3);
        $display("parallel 4-bit test done");
        rst(2'h1);
        h.db_out = 8'h2d;
        for (int i = 0; i < 3; i++) begin
            h.sel_out = (i == 2);
            h.ser({(i == 1) ? 6'h12 : 6'h2d, 2'h2});
            h.ser(8'hc3 + i);
            h.sel_out = 1;
            h.w(10);
            chk("ser", {wrs, wr}, {16'd4, 9'h1c3});
        end
        chk("ack", ack, 0);
        $display("clocked serial test done");
        h.strobe_out = 1'b1;
        h.rw_out = 1'b1;
        rst(2'h0);
        h.i2c(8'hb6, 1'b1);
        h.i2c(8'h5a, 1'b0);
        h.w(6);
        chk("i2c", {wrs, wr}, {16'd5, 9'h15a});
        chk("ack2", ack, 24);
        chk("oebad2", oebad, 0);
        $display("two-wire test done");
        end_of_test;
    end
endmodule
